// ===== rtl/pci_cfg_defs.svh
`ifndef PCI_CFG_DEFS_SVH
`define PCI_CFG_DEFS_SVH

// register byte offsets on the wishbone side
`define OFS_CONFIG_ADDRESS 8'h00
`define OFS_WINDOW_CONFIG 8'h04
`define OFS_STATUS 8'h08
// address bit that selects the pci window
`define WINDOW_SEL_BIT 31

// config_address_reg fields
`define CAR_ENABLE_BIT 31
`define CAR_BUS_HI 23
`define CAR_BUS_LO 16
`define CAR_DEV_HI 15
`define CAR_DEV_LO 11
`define CAR_FUNC_DW_HI 10
`define CAR_FUNC_DW_LO 2
`define DEV_ALL_ONES 5'h1f
`define DEV_FIRST_IDSEL 5'h0a
`define IDSEL_LINES 21
`define LOCAL_BUS 8'h00

// initiator_window_config fields
`define IWC_MEM_BIT 0
`define IWC_BASE_HI 31
`define IWC_BASE_LO 24

// status bits, write one to clear, except the read-only busy bit
`define ST_MASTER_ABORT 0
`define ST_TARGET_ABORT 1
`define ST_RETRY_LIMIT 2
`define ST_UNSUPPORTED 3
`define ST_BUSY 8
`define ST_WIDTH 4

// pci commands
`define CMD_INT_ACK 4'h0
`define CMD_SPECIAL 4'h1
`define CMD_IO_READ 4'h2
`define CMD_IO_WRITE 4'h3
`define CMD_MEM_READ 4'h6
`define CMD_MEM_WRITE 4'h7
`define CMD_CFG_READ 4'ha
`define CMD_CFG_WRITE 4'hb

// type 1 marker on ad[1:0]
`define TYPE1_LOW 2'h1
// pci clocks waited for a device select before master abort
`define DEVSEL_WAIT 3'h5
// retry terminations before the access fails
`define RETRY_LIMIT 4'h8
// device number that selects this bridge's own configuration space
`define SELF_DEVICE 5'h0a
`define ALL_ONES_DATA 32'hffffffff

`endif

// ===== rtl/pci_cfg_pkg.sv
`include "pci_cfg_defs.svh"

package pci_cfg_pkg;

  typedef enum logic [2:0] {S_IDLE, S_REQ, S_ADDR, S_DATA, S_END} state_t;

  typedef struct packed {
    state_t st;
    logic ack;
    logic err;
    logic [31:0] dat;
    logic [31:0] car;
    logic [31:0] iwc;
    logic [`ST_WIDTH-1:0] status;
    logic pclk_s1;
    logic pclk_s2;
    logic pclk_prev;
    logic [5:0] in_s1;
    logic [5:0] in_s2;
    logic [31:0] ad_s1;
    logic [31:0] ad_s2;
    logic req_n;
    logic frame_n;
    logic frame_oe;
    logic irdy_n;
    logic irdy_oe;
    logic [31:0] ad_o;
    logic ad_oe;
    logic [3:0] cbe_o;
    logic cbe_oe;
    logic self_idsel;
    logic self_hit;
    logic [31:0] addr;
    logic [3:0] cmd;
    logic [3:0] be;
    logic [31:0] wdat;
    logic write;
    logic special;
    logic [2:0] wait_cnt;
    logic [3:0] retry_cnt;
    logic again;
    logic fin_err;
  } regs_t;

endpackage

// ===== rtl/pci_config_cycle_generator.sv
`timescale 1ns/10ps
`include "pci_cfg_defs.svh"

module pci_config_cycle_generator (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [2:0] wb_cti_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic pci_clk_i,
  input wire logic gnt_n_i,
  output logic req_n_o,
  input wire logic frame_n_i,
  output logic frame_n_o,
  output logic frame_oe_o,
  input wire logic irdy_n_i,
  output logic irdy_n_o,
  output logic irdy_oe_o,
  input wire logic trdy_n_i,
  input wire logic devsel_n_i,
  input wire logic stop_n_i,
  input wire logic [31:0] pci_addr_data_lines_i,
  output logic [31:0] pci_addr_data_lines_o,
  output logic pci_addr_data_lines_oe_o,
  output logic [3:0] pci_cmd_byte_enable_o,
  output logic pci_cmd_byte_enable_oe_o,
  output logic self_idsel_o
);

  pci_cfg_pkg::regs_t r;
  pci_cfg_pkg::regs_t n;

  logic edge_seen;
  logic gnt_n;
  logic bus_frame_n;
  logic bus_irdy_n;
  logic trdy_n;
  logic devsel_n;
  logic stop_n;
  logic reg_hit;
  logic win_hit;
  logic io_space;
  logic cfg_en;
  logic [7:0] bus_num;
  logic [4:0] dev_num;
  logic [`IDSEL_LINES-1:0] idsel_vec;
  logic size_ok;
  logic burst;
  logic [1:0] low_byte;
  logic [31:0] rd_word;
  logic [31:0] wr_mask;
  logic [`ST_WIDTH-1:0] clr;

  ////////////////////////////////////////////////////////////////////////////
  // one-hot device select, one line per device number 10 to 30

  genvar gi;
  generate
    for (gi = 0; gi < `IDSEL_LINES; gi = gi + 1)
    begin : g_idsel
      assign idsel_vec[gi] = (dev_num == 5'(gi + 10));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    n = r;
    n.ack = 1'b0;
    n.err = 1'b0;

    // pci clock and pins pass two flops before use
    n.pclk_s1 = pci_clk_i;
    n.pclk_s2 = r.pclk_s1;
    n.pclk_prev = r.pclk_s2;
    n.in_s1 = {gnt_n_i, frame_n_i, irdy_n_i, trdy_n_i, devsel_n_i, stop_n_i};
    n.in_s2 = r.in_s1;
    n.ad_s1 = pci_addr_data_lines_i;
    n.ad_s2 = r.ad_s1;
    edge_seen = r.pclk_s2 & ~r.pclk_prev;
    gnt_n = r.in_s2[5];
    bus_frame_n = r.in_s2[4];
    bus_irdy_n = r.in_s2[3];
    trdy_n = r.in_s2[2];
    devsel_n = r.in_s2[1];
    stop_n = r.in_s2[0];

    // register fields
    cfg_en = r.car[`CAR_ENABLE_BIT];
    bus_num = r.car[`CAR_BUS_HI:`CAR_BUS_LO];
    dev_num = r.car[`CAR_DEV_HI:`CAR_DEV_LO];
    io_space = ~r.iwc[`IWC_MEM_BIT];

    // in io space only contiguous lanes inside one word reach the pci side
    size_ok = 1'b1;
    low_byte = 2'h0;
    unique case (wb_sel_i)
      4'h1, 4'h3, 4'h7, 4'hf: low_byte = 2'h0;
      4'h2, 4'h6, 4'he: low_byte = 2'h1;
      4'h4, 4'hc: low_byte = 2'h2;
      4'h8: low_byte = 2'h3;
      default: size_ok = 1'b0;
    endcase
    burst = (wb_cti_i != 3'h0) && (wb_cti_i != 3'h7);

    // register slave, answered one cycle after the strobe
    reg_hit = wb_cyc_i & wb_stb_i & ~wb_adr_i[`WINDOW_SEL_BIT] & ~r.ack;
    win_hit = wb_cyc_i & wb_stb_i & wb_adr_i[`WINDOW_SEL_BIT] & ~r.ack;
    rd_word = 32'h0;
    clr = '0;
    for (int i = 0; i < 4; i++)
    begin
      wr_mask[i*8 +: 8] = {8{wb_sel_i[i]}};
    end
    if (reg_hit)
    begin
      n.ack = 1'b1;
      unique case (wb_adr_i[7:0])
        `OFS_CONFIG_ADDRESS:
        begin
          rd_word = r.car;
          if (wb_we_i)
          begin
            n.car = (r.car & ~wr_mask) | (wb_dat_i & wr_mask);
          end
        end
        `OFS_WINDOW_CONFIG:
        begin
          rd_word = r.iwc;
          if (wb_we_i)
          begin
            n.iwc = (r.iwc & ~wr_mask) | (wb_dat_i & wr_mask);
          end
        end
        `OFS_STATUS:
        begin
          rd_word = 32'h0;
          rd_word[`ST_WIDTH-1:0] = r.status;
          rd_word[`ST_BUSY] = (r.st != pci_cfg_pkg::S_IDLE);
          if (wb_we_i && wb_sel_i[0])
          begin
            clr = wb_dat_i[`ST_WIDTH-1:0];
          end
        end
        default: rd_word = 32'h0;
      endcase
      n.dat = rd_word;
    end
    // later sets override this clear
    n.status = r.status & ~clr;

    unique case (r.st)
      pci_cfg_pkg::S_IDLE:
      begin
        if (win_hit)
        begin
          n.write = wb_we_i;
          n.wdat = wb_dat_i;
          n.be = ~wb_sel_i;
          n.special = 1'b0;
          n.self_hit = 1'b0;
          n.retry_cnt = 4'h0;
          if (io_space && (burst || !size_ok))
          begin
            // refused at once; no pci activity, no event beyond the flag
            n.ack = 1'b1;
            n.err = 1'b1;
            n.status[`ST_UNSUPPORTED] = 1'b1;
          end
          else
          begin
            n.st = pci_cfg_pkg::S_REQ;
            if (io_space && cfg_en && dev_num == `DEV_ALL_ONES && bus_num == `LOCAL_BUS)
            begin
              // fixed all-zero address pattern, function/dword unused
              n.addr = 32'h0;
              n.cmd = wb_we_i ? `CMD_SPECIAL : `CMD_INT_ACK;
              n.special = wb_we_i;
            end
            else if (io_space && cfg_en && bus_num == `LOCAL_BUS)
            begin
              n.addr = {idsel_vec, r.car[`CAR_FUNC_DW_HI:`CAR_FUNC_DW_LO], 2'h0};
              n.cmd = wb_we_i ? `CMD_CFG_WRITE : `CMD_CFG_READ;
              n.self_hit = (dev_num == `SELF_DEVICE);
            end
            else if (io_space && cfg_en)
            begin
              n.addr = {r.car[31:2], `TYPE1_LOW};
              n.cmd = wb_we_i ? `CMD_CFG_WRITE : `CMD_CFG_READ;
            end
            else if (io_space)
            begin
              n.addr = {r.iwc[`IWC_BASE_HI:`IWC_BASE_LO], wb_adr_i[23:2], low_byte};
              n.cmd = wb_we_i ? `CMD_IO_WRITE : `CMD_IO_READ;
            end
            else
            begin
              n.addr = {r.iwc[`IWC_BASE_HI:`IWC_BASE_LO], wb_adr_i[23:2], 2'h0};
              n.cmd = wb_we_i ? `CMD_MEM_WRITE : `CMD_MEM_READ;
            end
          end
        end
      end

      pci_cfg_pkg::S_REQ:
      begin
        n.req_n = 1'b0;
        // wait for grant on an idle bus before driving anything
        if (edge_seen && !gnt_n && bus_frame_n && bus_irdy_n)
        begin
          n.st = pci_cfg_pkg::S_ADDR;
          n.req_n = 1'b1;
          n.frame_n = 1'b0;
          n.frame_oe = 1'b1;
          n.ad_o = r.addr;
          n.ad_oe = 1'b1;
          n.cbe_o = r.cmd;
          n.cbe_oe = 1'b1;
          n.self_idsel = r.self_hit;
        end
      end

      pci_cfg_pkg::S_ADDR:
      begin
        if (edge_seen)
        begin
          // single data phase: frame goes high with irdy low
          n.st = pci_cfg_pkg::S_DATA;
          n.frame_n = 1'b1;
          n.irdy_n = 1'b0;
          n.irdy_oe = 1'b1;
          n.cbe_o = r.be;
          n.ad_o = r.wdat;
          n.ad_oe = r.write;
          n.self_idsel = 1'b0;
          n.wait_cnt = 3'h0;
          n.again = 1'b0;
          n.fin_err = 1'b0;
        end
      end

      pci_cfg_pkg::S_DATA:
      begin
        if (edge_seen)
        begin
          if (!devsel_n && !trdy_n)
          begin
            n.st = pci_cfg_pkg::S_END;
            n.irdy_n = 1'b1;
            n.dat = r.write ? 32'h0 : r.ad_s2;
          end
          else if (!stop_n && !devsel_n)
          begin
            n.st = pci_cfg_pkg::S_END;
            n.irdy_n = 1'b1;
            n.retry_cnt = r.retry_cnt + 4'h1;
            if (r.retry_cnt + 4'h1 == `RETRY_LIMIT)
            begin
              n.fin_err = 1'b1;
              n.status[`ST_RETRY_LIMIT] = 1'b1;
              n.dat = 32'h0;
            end
            else
            begin
              n.again = 1'b1;
            end
          end
          else if (!stop_n)
          begin
            n.st = pci_cfg_pkg::S_END;
            n.irdy_n = 1'b1;
            n.fin_err = 1'b1;
            n.status[`ST_TARGET_ABORT] = 1'b1;
            n.dat = 32'h0;
          end
          else if (devsel_n && r.wait_cnt == `DEVSEL_WAIT - 3'h1)
          begin
            // nobody claimed it: ones back, no bus error
            n.st = pci_cfg_pkg::S_END;
            n.irdy_n = 1'b1;
            n.dat = `ALL_ONES_DATA;
            if (!r.special)
            begin
              n.status[`ST_MASTER_ABORT] = 1'b1;
            end
            // special cycles always end this way and report nothing
            n.fin_err = 1'b0;
          end
          else
          begin
            n.wait_cnt = r.wait_cnt + 3'h1;
          end
        end
      end

      pci_cfg_pkg::S_END:
      begin
        if (edge_seen)
        begin
          n.frame_oe = 1'b0;
          n.irdy_oe = 1'b0;
          n.ad_oe = 1'b0;
          n.cbe_oe = 1'b0;
          if (r.again)
          begin
            n.st = pci_cfg_pkg::S_REQ;
          end
          else
          begin
            // acknowledge only after the pci data phase closed
            n.st = pci_cfg_pkg::S_IDLE;
            n.ack = 1'b1;
            n.err = r.fin_err;
          end
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r <= '0;
      r.req_n <= 1'b1;
      r.frame_n <= 1'b1;
      r.irdy_n <= 1'b1;
      r.in_s1 <= 6'h3f;
      r.in_s2 <= 6'h3f;
    end
    else
    begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign wb_dat_o = r.dat;
  assign wb_ack_o = r.ack & ~r.err;
  assign wb_err_o = r.err;
  assign req_n_o = r.req_n;
  assign frame_n_o = r.frame_n;
  assign frame_oe_o = r.frame_oe;
  assign irdy_n_o = r.irdy_n;
  assign irdy_oe_o = r.irdy_oe;
  assign pci_addr_data_lines_o = r.ad_o;
  assign pci_addr_data_lines_oe_o = r.ad_oe;
  assign pci_cmd_byte_enable_o = r.cbe_o;
  assign pci_cmd_byte_enable_oe_o = r.cbe_oe;
  assign self_idsel_o = r.self_idsel;

endmodule

// ===== verification/pci_cfg_props.sv
`timescale 1ns/10ps
module pci_cfg_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [2:0] wb_cti_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic frame_oe_o,
  input wire logic irdy_n_o,
  input wire logic irdy_oe_o,
  input wire logic [31:0] pci_addr_data_lines_o,
  input wire logic [3:0] pci_cmd_byte_enable_o,
  input wire logic pci_cmd_byte_enable_oe_o,
  input wire logic self_idsel_o
);
  logic [31:0] car;
  logic framed;
  logic fo_q;
  logic ap;
  logic b0;
  logic cfg;
  logic [4:0] dv;
  assign dv = car[15:11];
  assign b0 = car[23:16] == 8'h00;
  assign cfg = pci_cmd_byte_enable_o[3:1] == 3'h5;
  assign ap = frame_oe_o && !fo_q;
  ////////////////////////////////////////
  // shadow copy: offset 0 writes seen by the bench, byte lane by byte lane
  always_ff @(posedge clk_i)
  begin
    fo_q <= frame_oe_o;
    if (rst_i || wb_ack_o || wb_err_o)
      framed <= 1'b0;
    else if (frame_oe_o)
      framed <= 1'b1;
    if (rst_i)
      car <= 32'h0;
    else if (wb_ack_o && wb_we_i && wb_adr_i == 32'h0)
      for (int b = 0; b < 4; b++)
        if (wb_sel_i[b])
          car[8 * b +: 8] <= wb_dat_i[8 * b +: 8];
  end
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  AST_TYPE0_LOW: assert property (
    ap && cfg && b0 |-> pci_addr_data_lines_o[10:0] == {car[10:2], 2'h0})
    else $error("type 0 low address wrong");
  AST_IDSEL: assert property (
    ap && cfg && b0 |-> pci_addr_data_lines_o[31:11] ==
      (dv < 5'h0a ? 21'h0 : 21'h1 << (dv - 5'h0a))) else $error("idsel line wrong");
  AST_TYPE1: assert property (
    ap && cfg && !b0 |-> pci_addr_data_lines_o == {car[31:2], 2'h1})
    else $error("type 1 address wrong");
  AST_CFG_CMD: assert property (
    ap && car[31] && (dv != 5'h1f || !b0) |-> pci_cmd_byte_enable_o == {3'h5, wb_we_i})
    else $error("config command wrong");
  AST_SPECIAL_CMD: assert property (
    ap && car[31] && b0 && dv == 5'h1f |-> pci_cmd_byte_enable_o == {3'h0, wb_we_i})
    else $error("int ack or special command wrong");
  AST_IO_CMD: assert property (
    ap && !car[31] |-> !pci_cmd_byte_enable_o[3] && pci_cmd_byte_enable_o[1:0] == {1'b1, wb_we_i})
    else $error("plain transfer command wrong");
  AST_BYTE_EN: assert property (
    !irdy_n_o && irdy_oe_o && pci_cmd_byte_enable_oe_o |-> pci_cmd_byte_enable_o == ~wb_sel_i)
    else $error("byte enables wrong");
  AST_SELF: assert property (
    ap && cfg && b0 && dv == 5'h0a |-> self_idsel_o) else $error("own idsel missing");
  AST_NO_POST: assert property (
    wb_ack_o && wb_adr_i[31] |-> framed) else $error("window ack before pci transfer");
  AST_UNSUP: assert property (
    $rose(wb_stb_i) && wb_adr_i[31] && wb_cti_i == 3'h2 |-> ##[1:3] wb_err_o)
    else $error("burst not refused");
endmodule
bind pci_config_cycle_generator pci_cfg_props props (.clk_i(clk_i), .rst_i(rst_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_cti_i(wb_cti_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .frame_oe_o(frame_oe_o), .irdy_n_o(irdy_n_o), .irdy_oe_o(irdy_oe_o),
  .pci_addr_data_lines_o(pci_addr_data_lines_o), .pci_cmd_byte_enable_o(pci_cmd_byte_enable_o),
  .pci_cmd_byte_enable_oe_o(pci_cmd_byte_enable_oe_o), .self_idsel_o(self_idsel_o));

// ===== verification/pci_config_cycle_generator_tb.sv
`timescale 1ns/10ps
module pci_config_cycle_generator_tb;
  logic clk_i = 1'b0, rst_i = 1'b1, pclk = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [31:0] adr = 32'h0, wdat = 32'h0, rdata = 32'h0, ad_last = 32'h0, rd, car, d, dat, ad_o;
  logic [3:0] sel = 4'hf, cbe;
  logic [2:0] cti = 3'h0, mode = 3'h0;
  logic ok, er, w, ack, err, req_n, fr_n, fr_oe, ir_n, ir_oe, ad_oe, cbe_oe;
  logic gnt_n, dev_n, trdy_n, stop_n, p_en;
  logic [35:0] p_ap;
  logic [31:0] p_dat;
  logic [4:0] devs [8] = '{5'h0a, 5'h1f, 5'h1f, 5'h1f, 5'h03, 5'h09, 5'h1e, 5'h0b};
  logic [3:0] sels [8] = '{4'hf, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hc};
  int errors = 0, checks = 0, seed = 7365, i;
  // released lines: frame/irdy pulled up, ad floats so it wanders
  wire logic fr_w = fr_oe ? fr_n : 1'b1;
  wire logic ir_w = ir_oe ? ir_n : 1'b1;
  wire logic [31:0] ad_w = ad_oe ? ad_o : (p_en ? rdata : ~ad_last);
  always #25 clk_i = ~clk_i;
  initial
  begin
    #13;
    forever #200 pclk = ~pclk;
  end
  // cleared by reset so the floating bus toggles instead of staying unknown
  always @(posedge clk_i) ad_last <= rst_i ? 32'h0 : ad_w;
  pci_config_cycle_generator DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_cti_i(cti), .wb_dat_i(wdat),
    .wb_dat_o(dat), .wb_ack_o(ack), .wb_err_o(err), .pci_clk_i(pclk), .gnt_n_i(gnt_n),
    .req_n_o(req_n), .frame_n_i(fr_w), .frame_n_o(fr_n), .frame_oe_o(fr_oe), .irdy_n_i(ir_w),
    .irdy_n_o(ir_n), .irdy_oe_o(ir_oe), .trdy_n_i(trdy_n), .devsel_n_i(dev_n),
    .stop_n_i(stop_n), .pci_addr_data_lines_i(ad_w), .pci_addr_data_lines_o(ad_o),
    .pci_addr_data_lines_oe_o(ad_oe), .pci_cmd_byte_enable_o(cbe),
    .pci_cmd_byte_enable_oe_o(cbe_oe), .self_idsel_o());
  pci_target_model far (.pci_clk_i(pclk), .req_n_i(req_n), .frame_n_i(fr_w), .irdy_n_i(ir_w),
    .ad_i(ad_w), .cbe_i(cbe), .mode_i(mode), .gnt_n_o(gnt_n), .devsel_n_o(dev_n),
    .trdy_n_o(trdy_n), .stop_n_o(stop_n), .ad_en_o(p_en), .cap_ap_o(p_ap), .cap_data_o(p_dat));
  ////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // classic cycle; request held until the edge that samples ack or err, released there
  task automatic wb(input logic wr, input logic [31:0] a, input logic [3:0] s,
    input logic [31:0] dt, input logic [2:0] t);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we} <= {2'h3, wr};
    adr <= a;
    sel <= s;
    wdat <= dt;
    cti <= t;
    @(posedge clk_i);
    while (ack !== 1'b1 && err !== 1'b1 && n < 4000)
    begin
      @(posedge clk_i);
      n++;
    end
    if (ack !== 1'b1 && err !== 1'b1)
    begin
      errors++;
      summarize();
    end
    // values seen here are those sampled at this rising edge
    {rd, ok, er} = {dat, ack, err};
    {cyc, stb} <= 2'h0;
  endtask
  function automatic logic [35:0] exp_ap(input logic [31:0] c, input logic wr);
    logic [31:0] a;
    a = 32'h0;
    if (c[23:16] != 8'h00)
      return {3'h5, wr, c[31:2], 2'h1};
    if (c[15:11] == 5'h1f)
      return {3'h0, wr, 32'h0};
    if (c[15:11] >= 5'h0a)
      a = 32'h800 << (c[15:11] - 5'h0a);
    return {3'h5, wr, a[31:11], c[10:2], 2'h0};
  endfunction
  ////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 4; i++)
    begin
      wb(1'b0, 32'(i * 4), 4'hf, 32'h0, 3'h0);
      chk(rd, 36'h0);
    end
    wb(1'b1, 32'h4, 4'hf, 32'ha5000000, 3'h0);
    rdata <= $random(seed);
    wb(1'b0, 32'h80123456, 4'hc, 32'h0, 3'h0);
    chk(rd, rdata);
    chk(p_ap, {4'h2, 8'ha5, 22'h048d15, 2'h2});
    for (i = 0; i < 16; i++)
    begin
      car = $random(seed);
      car[31:24] = 8'h80;
      car[1:0] = 2'h0;
      if (i % 4 != 1)
        car[23:16] = 8'h00;
      else
        car[16] = 1'b1;
      if (i < 8)
        car[15:11] = devs[i];
      w = i[0];
      d = $random(seed);
      mode <= {1'($random(seed)), 2'h0};
      rdata <= $random(seed);
      wb(1'b1, 32'h0, 4'hf, car, 3'h0);
      wb(1'b0, 32'h0, 4'hf, 32'h0, 3'h0);
      chk(rd, car);
      wb(w, 32'h80000000, sels[i % 8], d, 3'h0);
      chk({ok, er}, 36'h2);
      chk(p_ap, exp_ap(car, w));
      chk(w ? p_dat : rd, w ? d : rdata);
    end
    wb(1'b1, 32'h0, 4'hf, 32'h8000f800, 3'h0);
    for (i = 0; i < 3; i++)
    begin
      d = {16'($random(seed)), 16'(i)};
      wb(1'b1, 32'h80000000, 4'hf, d, 3'h0);
      chk({ok, er, p_dat}, {2'h2, d});
      wb(1'b0, 32'h8, 4'hf, 32'h0, 3'h0);
      chk(rd, 36'h0);
    end
    wb(1'b1, 32'h0, 4'hf, 32'h80006000, 3'h0);
    for (i = 1; i < 4; i++)
    begin
      mode <= 3'(i);
      wb(1'b0, 32'h80000000, 4'hf, 32'h0, 3'h0);
      chk({ok, er, i == 1 ? rd : 32'hffffffff}, {i == 1, i != 1, 32'hffffffff});
      wb(1'b0, 32'h8, 4'hf, 32'h0, 3'h0);
      chk(rd, 36'h1 << (i - 1));
      wb(1'b1, 32'h8, 4'h1, 32'hf, 3'h0);
    end
    mode <= 3'h0;
    wb(1'b0, 32'h80000000, 4'hf, 32'h0, 3'h2);
    chk({ok, er}, 36'h1);
    wb(1'b1, 32'h80000000, 4'h5, 32'h0, 3'h0);
    chk({ok, er}, 36'h1);
    wb(1'b0, 32'h8, 4'hf, 32'h0, 3'h0);
    chk(rd, 36'h8);
    summarize();
  end
endmodule

// ===== verification/pci_target_model.sv
`timescale 1ns/10ps
module pci_target_model (
  input wire logic pci_clk_i,
  input wire logic req_n_i,
  input wire logic frame_n_i,
  input wire logic irdy_n_i,
  input wire logic [31:0] ad_i,
  input wire logic [3:0] cbe_i,
  input wire logic [2:0] mode_i,
  output logic gnt_n_o,
  output logic devsel_n_o,
  output logic trdy_n_o,
  output logic stop_n_o,
  output logic ad_en_o,
  output logic [35:0] cap_ap_o,
  output logic [31:0] cap_data_o
);
  logic fr_q = 1'b1;
  logic act = 1'b0;
  logic [1:0] cnt = 2'h0;
  initial {gnt_n_o, devsel_n_o, trdy_n_o, stop_n_o, ad_en_o} = 5'h1e;
  ////////////////////////////////////////
  // mode: 0 claim, 1 silent, 2 target abort, 3 retry; bit 2 slows the claim
  always @(posedge pci_clk_i)
  begin
    gnt_n_o <= req_n_i;
    fr_q <= frame_n_i;
    if (!irdy_n_i)
      cap_data_o <= ad_i;
    if (fr_q && !frame_n_i)
    begin
      cap_ap_o <= {cbe_i, ad_i};
      act <= 1'b1;
      cnt <= mode_i[2] ? 2'h2 : 2'h0;
    end
    else if (act && !irdy_n_i && cnt != 2'h0)
      cnt <= cnt - 2'h1;
    else if (act && !irdy_n_i && cap_ap_o[35:32] != 4'h1)
    begin
      devsel_n_o <= mode_i[1:0] == 2'h1 || mode_i[1:0] == 2'h2;
      trdy_n_o <= mode_i[1:0] != 2'h0;
      stop_n_o <= !mode_i[1];
      ad_en_o <= mode_i[1:0] == 2'h0 && !cap_ap_o[32];
    end
    if (act && frame_n_i && irdy_n_i)
    begin
      {devsel_n_o, trdy_n_o, stop_n_o, ad_en_o} <= 4'he;
      act <= 1'b0;
    end
  end
endmodule
